// ### slr_core.sv
// SATA port lock-up and recovery core: frame receive, stall states, registers
// Operation
// - Write-direction PIO setup frame with busy and data-request clear sets status and stalls until reset
// - Link lock-up sets fatal-error bit 27, link-sequence bit 23; command times out
// - Lock-up follows escape after a device frame, or corrupted continue primitive in PIO read
// - In link lock-up a soft reset does not recover; only a port reset does
// - Register frame over eight doublewords overflows receive FIFO and locks controller
`timescale 1ns/100ps
module slr_core #(
  parameter int LINK_INIT_CYCLES = slr_pkg::LINK_INIT_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Receive link side, and software reset
  input  wire logic        rx_sof_i,
  input  wire logic        rx_valid_i,
  input  wire logic [31:0] rx_data_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_escape_i,
  input  wire logic        rx_cont_bad_i,
  input  wire logic        soft_reset_i,
  // Link control and status
  output logic             comreset_o,
  output logic             link_up_o,
  output logic             locked_o
);
  slr_pkg::slr_state_e state_r;
  slr_pkg::slr_state_e state_nxt;

  logic [31:0] int_stat_r;
  logic [7:0]  task_file_r;
  logic [31:0] serr_r;
  logic [3:0]  det_r;
  logic        emul_r;
  logic        pio_frame_r;
  logic [7:0]  rx_type_r;
  logic [$clog2(LINK_INIT_CYCLES+1)-1:0] init_cnt_r;
  logic        port_reset;
  logic        fifo_empty;
  logic        fifo_ovf;
  logic [31:0] fifo_rdata;
  logic        fifo_wr;
  logic        pio_hazard;

  // Port reset pulse whenever the detection field is written to one
  assign port_reset = reg_wr_i && (reg_addr_i == slr_pkg::ADDR_SCTL)
                      && (reg_wdata_i[slr_pkg::SCTL_DET_LSB +: slr_pkg::SCTL_DET_W]
                          == slr_pkg::DET_COMRESET);
  assign fifo_wr    = rx_valid_i && (state_r == slr_pkg::SLR_RX_FRAME);
  assign pio_hazard = !task_file_r[slr_pkg::TFD_BUSY_BIT]
                      && !task_file_r[slr_pkg::TFD_DRQ_BIT];

  // Drained only between frames, so a frame longer than the buffer overflows it
  slr_rx_fifo #(
    .WIDTH (32),
    .DEPTH (slr_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .flush_i    (port_reset),
    .wr_i       (fifo_wr),
    .wdata_i    (rx_data_i),
    .rd_i       (!fifo_empty && (state_r != slr_pkg::SLR_RX_FRAME)),
    .rdata_o    (fifo_rdata),
    .empty_o    (fifo_empty),
    .overflow_o (fifo_ovf)
  );

  // Next state; soft reset frees only the PIO stall, and has no effect in link lock or receive lock
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      slr_pkg::SLR_LINK_INIT:
      begin
        if (init_cnt_r == '0)
        begin
          state_nxt = slr_pkg::SLR_IDLE;
        end
      end
      slr_pkg::SLR_IDLE:
      begin
        if (rx_cont_bad_i)
        begin
          state_nxt = slr_pkg::SLR_LINK_LOCK;
        end
        else if (rx_sof_i)
        begin
          state_nxt = slr_pkg::SLR_RX_FRAME;
        end
      end
      slr_pkg::SLR_RX_FRAME:
      begin
        if (rx_escape_i || rx_cont_bad_i)
        begin
          state_nxt = slr_pkg::SLR_LINK_LOCK;
        end
        else if (fifo_ovf && rx_type_r == slr_pkg::FIS_REG_D2H)
        begin
          state_nxt = slr_pkg::SLR_RX_LOCK;
        end
        else if (rx_eof_i)
        begin
          state_nxt = (pio_frame_r && pio_hazard) ? slr_pkg::SLR_PIO_STALL
                                                  : slr_pkg::SLR_IDLE;
        end
      end
      slr_pkg::SLR_PIO_STALL:
      begin
        if (soft_reset_i)
        begin
          state_nxt = slr_pkg::SLR_IDLE;
        end
      end
      slr_pkg::SLR_LINK_LOCK,
      slr_pkg::SLR_RX_LOCK:
      begin
        state_nxt = state_r;
      end
      default:
      begin
        state_nxt = slr_pkg::SLR_LINK_INIT;
      end
    endcase
    if (port_reset)
    begin
      state_nxt = slr_pkg::SLR_LINK_INIT;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_r <= slr_pkg::SLR_LINK_INIT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Link initialisation timer, reloaded by each port reset
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || port_reset)
    begin
      init_cnt_r <= ($clog2(LINK_INIT_CYCLES+1))'(LINK_INIT_CYCLES);
    end
    else if (init_cnt_r != '0)
    begin
      init_cnt_r <= init_cnt_r - 1'b1;
    end
  end

  // Frame type capture; first word of each frame carries it
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || port_reset)
    begin
      rx_type_r   <= 8'h00;
      pio_frame_r <= 1'b0;
    end
    else if (state_r == slr_pkg::SLR_IDLE && rx_sof_i)
    begin
      rx_type_r   <= rx_data_i[7:0];
      // Only device-bound PIO setup (write direction) triggers the stall
      pio_frame_r <= (rx_data_i[7:0] == slr_pkg::FIS_PIO_SETUP) && !rx_data_i[13];
    end
  end

  // Task-file shadow: status byte of the buffer head, the first word of a frame
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || port_reset)
    begin
      task_file_r <= 8'h00;
    end
    else if (!fifo_empty)
    begin
      task_file_r <= fifo_rdata[23:16];
    end
  end

  // Interrupt status: hardware sets win over a same-cycle write-one clear
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      int_stat_r <= slr_pkg::RESET_WORD;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == slr_pkg::ADDR_INT_STAT)
      begin
        int_stat_r <= int_stat_r & ~reg_wdata_i;
      end
      if (state_r != slr_pkg::SLR_PIO_STALL && state_nxt == slr_pkg::SLR_PIO_STALL)
      begin
        int_stat_r[slr_pkg::IS_PIO_SETUP_BIT] <= 1'b1;
      end
      if (state_r != slr_pkg::SLR_LINK_LOCK && state_nxt == slr_pkg::SLR_LINK_LOCK)
      begin
        int_stat_r[slr_pkg::IS_FATAL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      serr_r <= slr_pkg::RESET_WORD;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == slr_pkg::ADDR_SERR)
      begin
        serr_r <= serr_r & ~reg_wdata_i;
      end
      if (state_r != slr_pkg::SLR_LINK_LOCK && state_nxt == slr_pkg::SLR_LINK_LOCK)
      begin
        serr_r[slr_pkg::SERR_LINK_SEQ_BIT] <= 1'b1;
      end
    end
  end

  // Serial control and a spare read-write control bit
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      det_r  <= slr_pkg::DET_NONE;
      emul_r <= slr_pkg::CTRL_RESET[slr_pkg::CTRL_EMUL_BIT];
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == slr_pkg::ADDR_SCTL)
      begin
        det_r <= reg_wdata_i[slr_pkg::SCTL_DET_LSB +: slr_pkg::SCTL_DET_W];
      end
      if (reg_addr_i == slr_pkg::ADDR_CTRL)
      begin
        emul_r <= reg_wdata_i[slr_pkg::CTRL_EMUL_BIT];
      end
    end
  end

  // Read data, one cycle after the strobe, zero otherwise and for unmapped addresses
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || !reg_rd_i)
    begin
      reg_rdata_o <= slr_pkg::RESET_WORD;
    end
    else
    begin
      case (reg_addr_i)
        slr_pkg::ADDR_INT_STAT:  reg_rdata_o <= int_stat_r;
        slr_pkg::ADDR_TASK_FILE: reg_rdata_o <= {24'h000000, task_file_r};
        slr_pkg::ADDR_SERR:      reg_rdata_o <= serr_r;
        slr_pkg::ADDR_SCTL:      reg_rdata_o <= {28'h0000000, det_r};
        slr_pkg::ADDR_STATE:     reg_rdata_o <= {29'h00000000, state_r};
        slr_pkg::ADDR_CTRL:      reg_rdata_o <= {31'h00000000, emul_r};
        default:                 reg_rdata_o <= slr_pkg::RESET_WORD;
      endcase
    end
  end

  // Link outputs, all registered
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      comreset_o <= 1'b0;
      link_up_o  <= 1'b0;
      locked_o   <= 1'b0;
    end
    else
    begin
      comreset_o <= port_reset;
      link_up_o  <= (state_nxt != slr_pkg::SLR_LINK_INIT);
      locked_o   <= (state_nxt == slr_pkg::SLR_PIO_STALL)
                    || (state_nxt == slr_pkg::SLR_LINK_LOCK)
                    || (state_nxt == slr_pkg::SLR_RX_LOCK);
    end
  end

  // Checks
  sequence s_link_err;
    (state_r == slr_pkg::SLR_RX_FRAME) && rx_escape_i && !port_reset;
  endsequence

  AST_PIO_STALL_SETS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_r != slr_pkg::SLR_PIO_STALL && state_nxt == slr_pkg::SLR_PIO_STALL)
    |=> int_stat_r[slr_pkg::IS_PIO_SETUP_BIT] && locked_o)
    else $error("PIO stall did not set status and lock");

  AST_COMRESET_PULSE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    port_reset |=> comreset_o && !link_up_o)
    else $error("port reset did not pulse comreset");

  AST_LINK_LOCK_BITS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_link_err |=> int_stat_r[slr_pkg::IS_FATAL_BIT] && serr_r[slr_pkg::SERR_LINK_SEQ_BIT])
    else $error("link lock did not set error bits");

  AST_ESCAPE_LOCKS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_link_err |=> state_r == slr_pkg::SLR_LINK_LOCK)
    else $error("escape did not lock the link");
  AST_SOFT_NO_RECOVER: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_r == slr_pkg::SLR_LINK_LOCK && soft_reset_i && !port_reset)
    |=> state_r == slr_pkg::SLR_LINK_LOCK)
    else $error("soft reset left link lock");
  AST_OVERSIZE_LOCK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_r == slr_pkg::SLR_RX_FRAME && fifo_ovf && rx_type_r == slr_pkg::FIS_REG_D2H
     && !rx_escape_i && !rx_cont_bad_i && !port_reset)
    |=> state_r == slr_pkg::SLR_RX_LOCK ##1 locked_o)
    else $error("oversized register frame did not lock");
  AST_PORT_RESET_CLEARS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    port_reset |=> state_r == slr_pkg::SLR_LINK_INIT && !fifo_ovf && fifo_empty)
    else $error("port reset did not clear state");

  AST_INIT_TIME: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(link_up_o) |-> !link_up_o [*2])
    else $error("link came up too soon");
endmodule

// ### slr_pkg.sv
// Package: register map, fields and constants of the SATA lock-up recovery block
package slr_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_INT_STAT  = 8'h00;
  localparam logic [7:0] ADDR_TASK_FILE = 8'h04;
  localparam logic [7:0] ADDR_SERR      = 8'h08;
  localparam logic [7:0] ADDR_SCTL      = 8'h0C;
  localparam logic [7:0] ADDR_STATE     = 8'h10;
  localparam logic [7:0] ADDR_CTRL      = 8'h14;

  // Field positions
  localparam int IS_PIO_SETUP_BIT  = 1;
  localparam int IS_FATAL_BIT      = 27;
  localparam int TFD_BUSY_BIT      = 7;
  localparam int TFD_DRQ_BIT       = 3;
  localparam int SERR_LINK_SEQ_BIT = 23;
  localparam int SCTL_DET_LSB      = 0;
  localparam int SCTL_DET_W        = 4;
  localparam int CTRL_EMUL_BIT     = 0;

  // Field values and reset values
  localparam logic [3:0]  DET_COMRESET  = 4'h1;
  localparam logic [3:0]  DET_NONE      = 4'h0;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;

  // Frame type codes on the receive side
  localparam logic [7:0] FIS_REG_D2H   = 8'h34;
  localparam logic [7:0] FIS_PIO_SETUP = 8'h5F;

  // Receive FIFO depth in doublewords; a register frame holds at most this many
  localparam int RX_FIFO_DEPTH = 8;

  // Link initialisation time after a port reset
  localparam int  CLK_MHZ        = 25;
  localparam int  LINK_INIT_NS   = 1000;
  localparam int  LINK_INIT_CYC  = (LINK_INIT_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SLR_LINK_INIT,
    SLR_IDLE,
    SLR_RX_FRAME,
    SLR_PIO_STALL,
    SLR_LINK_LOCK,
    SLR_RX_LOCK
  } slr_state_e;

endpackage

// ### slr_rx_fifo.sv
// Receive FIFO with overflow flag, flushed on port reset
`timescale 1ns/100ps
module slr_rx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = slr_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // Drain side
  input  wire logic             rd_i,
  output logic      [WIDTH-1:0] rdata_o,
  // Status
  output logic                  empty_o,
  output logic                  overflow_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             full;
  logic             do_wr;
  logic             do_rd;

  assign full    = (cnt_r == (AW+1)'(DEPTH));
  assign empty_o = (cnt_r == '0);
  assign do_wr   = wr_i && !full;
  assign do_rd   = rd_i && !empty_o;
  assign rdata_o = mem_r[rp_r];

  always_ff @(posedge ref_clk_i)
  begin
    if (do_wr)
    begin
      mem_r[wp_r] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || flush_i)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (do_rd)
      begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Overflow sticks until the FIFO is flushed
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || flush_i)
    begin
      overflow_o <= 1'b0;
    end
    else if (wr_i && !do_wr)
    begin
      overflow_o <= 1'b1;
    end
  end
endmodule

// ### slr_dev_model.sv
// Device model: sends device-to-host frames onto the host's receive link side
`timescale 1ns/100ps
module slr_dev_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Link toward the host
  output logic             sof_o,
  output logic             valid_o,
  output logic      [31:0] data_o,
  output logic             eof_o,
  output logic             escape_o,
  output logic             cont_bad_o
);
  initial
  begin
    sof_o      = 1'b0;
    valid_o    = 1'b0;
    data_o     = 32'h0000_0000;
    eof_o      = 1'b0;
    escape_o   = 1'b0;
    cont_bad_o = 1'b0;
  end

  // Type, direction and status ride in every word, whichever word the host decodes
  task automatic send(input logic [7:0] typ, input logic dir, input logic [7:0] sts,
                      input int n, input int fault);
    logic [31:0] w;
    begin
      w = {8'h00, sts, 2'b00, dir, 5'h00, typ};
      @(posedge ref_clk_i);
      sof_o <= 1'b1;
      data_o <= w;
      for (int i = 0; i < n; i++)
      begin
        @(posedge ref_clk_i);
        sof_o <= 1'b0;
        valid_o <= 1'b1;
        escape_o <= (fault == 1) && (i == n - 1);
        cont_bad_o <= (fault == 2) && (i == n - 1);
      end
      @(posedge ref_clk_i);
      valid_o <= 1'b0;
      escape_o <= 1'b0;
      cont_bad_o <= 1'b0;
      eof_o <= 1'b1;
      @(posedge ref_clk_i);
      eof_o <= 1'b0;
      // Released data line shows the inverse, so a stale word never looks valid
      data_o <= ~w;
    end
  endtask
endmodule

// ### slr_core_bench.sv
// Testbench: lock-up and recovery of the SATA port core
`timescale 1ns/100ps
module slr_core_bench;
  // Short link init keeps the run brief
  localparam int LI = 8;
  logic        ref_clk_i;
  logic        reset_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        rx_sof_i;
  logic        rx_valid_i;
  logic [31:0] rx_data_i;
  logic        rx_eof_i;
  logic        rx_escape_i;
  logic        rx_cont_bad_i;
  logic        soft_reset_i;
  logic        comreset_o;
  logic        link_up_o;
  logic        locked_o;
  int          error_cnt;
  int          n_tests;
  int          cnt;
  logic [31:0] v;

  slr_core #(.LINK_INIT_CYCLES(LI)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_sof_i(rx_sof_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_eof_i(rx_eof_i), .rx_escape_i(rx_escape_i),
    .rx_cont_bad_i(rx_cont_bad_i), .soft_reset_i(soft_reset_i),
    .comreset_o(comreset_o), .link_up_o(link_up_o), .locked_o(locked_o));

  slr_dev_model dev (
    .ref_clk_i(ref_clk_i), .sof_o(rx_sof_i), .valid_o(rx_valid_i), .data_o(rx_data_i),
    .eof_o(rx_eof_i), .escape_o(rx_escape_i), .cont_bad_o(rx_cont_bad_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  // Software reset: both host register frames done, told to the core by one pulse
  task automatic sreset();
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    settle();
  endtask

  task automatic port_reset();
    logic seen;
    seen = 1'b0;
    wr(slr_pkg::ADDR_SCTL, {28'h0, slr_pkg::DET_COMRESET});
    for (int i = 0; i < 3; i++)
    begin
      #1 seen = seen | (comreset_o === 1'b1);
      @(posedge ref_clk_i);
    end
    chk(seen, 1, "comreset pulse");
    cnt = 0;
    while (link_up_o !== 1'b1 && cnt < LI + 20)
    begin
      @(posedge ref_clk_i);
      cnt++;
    end
    chk(link_up_o, 1, "link up after port reset");
    settle();
    chk(locked_o, 0, "unlocked after port reset");
    rdchk(slr_pkg::ADDR_STATE, 32'h1, "idle after port reset");
  endtask

  task automatic test_done();
    $display("tests %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge ref_clk_i);
    error_cnt++;
    test_done();
  end

  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    reset_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    soft_reset_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1 chk(link_up_o, 0, "link down in init");
    chk(locked_o, 0, "not locked after reset");
    rdchk(slr_pkg::ADDR_STATE, 32'h0, "init state");
    rdchk(slr_pkg::ADDR_CTRL, slr_pkg::CTRL_RESET, "ctrl reset");
    rdchk(slr_pkg::ADDR_INT_STAT, 32'h0, "int status reset");
    rdchk(slr_pkg::ADDR_SERR, 32'h0, "serror reset");
    wr(slr_pkg::ADDR_CTRL, 32'h0);
    rdchk(slr_pkg::ADDR_CTRL, 32'h0, "ctrl written");
    wr(8'h18, 32'hFFFF_FFFF);
    rdchk(8'h18, 32'h0, "unmapped reads zero");
    settle();
    chk(link_up_o, 1, "link up after init");
    $display("test registers done");
    // Stall only for a write-direction setup frame with busy and data-request clear
    for (int k = 0; k < 4; k++)
    begin
      dev.send(slr_pkg::FIS_PIO_SETUP, k == 3, k == 1 ? 8'h80 : k == 2 ? 8'h08 : 8'h00, 2, 0);
      settle();
      rdchk(slr_pkg::ADDR_STATE, k == 0 ? 32'h3 : 32'h1, "setup frame state");
      chk(locked_o, k == 0, "setup frame lock");
      rdchk(slr_pkg::ADDR_TASK_FILE, k == 1 ? 32'h80 : k == 2 ? 32'h8 : 32'h0, "status");
      rd(slr_pkg::ADDR_INT_STAT, v);
      chk(v[slr_pkg::IS_PIO_SETUP_BIT], k == 0, "setup status bit");
      wr(slr_pkg::ADDR_INT_STAT, 32'h2);
      rdchk(slr_pkg::ADDR_INT_STAT, 32'h0, "status cleared");
      if (k == 0)
        sreset();
      chk(locked_o, 0, "soft reset frees setup stall");
    end
    $display("test setup stall done");
    // Escape after a device frame, then a bad continue primitive during a PIO read
    for (int f = 1; f < 3; f++)
    begin
      dev.send(f == 1 ? slr_pkg::FIS_REG_D2H : slr_pkg::FIS_PIO_SETUP, f == 2, 8'h58, 3, f);
      settle();
      rdchk(slr_pkg::ADDR_STATE, 32'h4, "link lock state");
      rd(slr_pkg::ADDR_INT_STAT, v);
      chk(v[slr_pkg::IS_FATAL_BIT], 1, "fatal bit");
      rd(slr_pkg::ADDR_SERR, v);
      chk(v[slr_pkg::SERR_LINK_SEQ_BIT], 1, "link sequence bit");
      chk(locked_o, 1, "link lock");
      sreset();
      rdchk(slr_pkg::ADDR_STATE, 32'h4, "soft reset does not help");
      chk(locked_o, 1, "still locked");
      port_reset();
      wr(slr_pkg::ADDR_SERR, 32'h0080_0000);
      wr(slr_pkg::ADDR_INT_STAT, 32'h0800_0000);
      rdchk(slr_pkg::ADDR_SERR, 32'h0, "serror cleared");
      rdchk(slr_pkg::ADDR_INT_STAT, 32'h0, "fatal cleared");
    end
    $display("test link lock done");
    // Eight words fit the receive buffer, nine overflow it
    for (int n = 8; n < 10; n++)
    begin
      dev.send(slr_pkg::FIS_REG_D2H, 1'b0, 8'h50, n, 0);
      settle();
      rdchk(slr_pkg::ADDR_STATE, n > 8 ? 32'h5 : 32'h1, "register frame length");
      chk(locked_o, n > 8, "overflow lock");
      if (n > 8)
      begin
        sreset();
        chk(locked_o, 1, "overflow stays locked");
        port_reset();
      end
    end
    // A full-size frame after the port reset shows the buffer and its overflow were flushed
    dev.send(slr_pkg::FIS_REG_D2H, 1'b0, 8'h50, 8, 0);
    settle();
    rdchk(slr_pkg::ADDR_STATE, 32'h1, "flushed buffer takes full frame");
    $display("test overflow done");
    test_done();
  end
endmodule
